// file: include/srx_pkg.sv
// package: constants shared by the subroutine return slice and its stack
package srx_pkg;
   // instruction word, pointer and flag widths
   localparam int unsigned WORD_W  = 16;
   localparam int unsigned SP_W    = 4;
   localparam int unsigned FLAGS_W = 8;
   // stack storage depth in words, follows the pointer width
   localparam int unsigned STACK_DEPTH = 16;
   // fixed encoding of the unconditional return, no operand field
   localparam logic [15:0] RETURN_OPCODE = 16'h8c0d;
   // reset values
   localparam logic [15:0] IP_RESET    = 16'h0000;
   localparam logic [3:0]  SP_RESET    = 4'h0;
   localparam logic [7:0]  FLAGS_RESET = 8'h00;
   localparam logic [15:0] RDATA_RESET = 16'h0000;
   // pointer steps for pop, push and sequential fetch
   localparam logic [3:0]  SP_STEP     = 4'h1;
   localparam logic [15:0] IP_STEP     = 16'h0001;
endpackage : srx_pkg

// file: include/srx_stack_if.sv
// interface: stack storage port between execution slice and memory
`timescale 1ns/1ps
`default_nettype none
interface srx_stack_if;
   logic        wrEn;    // write strobe for one stack word
   logic [3:0]  wrAddr;  // slot written
   logic [15:0] wrData;  // word written
   logic [3:0]  rdAddr;  // slot that becomes top of stack next cycle
   logic [15:0] rdData;  // registered word at the current top
   modport core (output wrEn, output wrAddr, output wrData,
                 output rdAddr, input rdData);
   modport mem  (input wrEn, input wrAddr, input wrData,
                 input rdAddr, output rdData);
endinterface : srx_stack_if
`default_nettype wire

// file: src/srx_stack_mem.sv
// module: small stack memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module srx_stack_mem (
   input  wire logic clock,
   input  wire logic resetn,
   srx_stack_if.mem  bus
);
   ////////////////////////////////////////////////////////////////////////
   // storage array, never reset, contents undefined until pushed
   logic [15:0] mem [srx_pkg::STACK_DEPTH];
   logic [15:0] rdData_q;   // registered top word
   logic [15:0] rdData_d;   // next top word

   ////////////////////////////////////////////////////////////////////////
   // next read word, with write-through so a push is visible at once
   always_comb begin
      rdData_d = mem[bus.rdAddr];
      // same-slot write wins, the array still holds the old word
      if (bus.wrEn && (bus.wrAddr == bus.rdAddr)) begin
         rdData_d = bus.wrData;
      end
   end

   // array write, no reset on storage
   always_ff @(posedge clock) begin
      if (bus.wrEn) begin
         mem[bus.wrAddr] <= bus.wrData;
      end
   end

   // read register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdData_q <= srx_pkg::RDATA_RESET;
      end else begin
         rdData_q <= rdData_d;
      end
   end

   assign bus.rdData = rdData_q;
endmodule : srx_stack_mem
`default_nettype wire

// file: src/srx_return_exec.sv
// module: execution slice for the unconditional subroutine return
// Contract
// - return loads pointer from top stack word
// - return increments stack pointer, shrinking depth
// - return leaves all status flags unchanged
// - decode word 8c0d as the return
`timescale 1ns/1ps
`default_nettype none
module srx_return_exec (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        instrValid,         // instruction word present
   input  wire logic [15:0] instrWord,          // decoded this cycle
   input  wire logic        pushValid,          // push one word this cycle
   input  wire logic [15:0] pushData,           // word to push
   input  wire logic        flagWrEn,           // other op updates flags
   input  wire logic [7:0]  flagWrData,         // new flag values
   output var  logic [15:0] instructionPointer, // address of next fetch
   output var  logic [3:0]  stackPointer,       // current top slot
   output var  logic [7:0]  statusFlags,        // processor status
   output var  logic        returnDone          // pulse: return executed
);
   ////////////////////////////////////////////////////////////////////////
   // decode helper, used by the datapath and by the checks
   function automatic logic srx_is_return(input logic [15:0] word);
      // exact match, the encoding carries no operand bits
      // conditional returns differ only in the top nibble, so no mask
      srx_is_return = (word == srx_pkg::RETURN_OPCODE);
   endfunction : srx_is_return

   ////////////////////////////////////////////////////////////////////////
   // stack storage link
   srx_stack_if stackBus ();

   srx_stack_mem u_stackMem (
      .clock  (clock),
      .resetn (resetn),
      .bus    (stackBus.mem)
   );

   ////////////////////////////////////////////////////////////////////////
   // architectural state
   logic [15:0] ip_q;      // instruction pointer
   logic [15:0] ip_d;
   logic [3:0]  sp_q;      // stack pointer, grows downward
   logic [3:0]  sp_d;
   logic [7:0]  flags_q;   // status flags
   logic [7:0]  flags_d;
   logic        done_q;    // return strobe
   logic        done_d;
   logic        isReturn;  // return decoded this cycle

   ////////////////////////////////////////////////////////////////////////
   // next-state logic for pointers, flags and stack port
   always_comb begin
      ip_d    = ip_q;
      sp_d    = sp_q;
      flags_d = flags_q;
      done_d  = 1'b0;
      stackBus.wrEn   = 1'b0;
      // push slot sits one below the current top, stack grows downward
      stackBus.wrAddr = sp_q - srx_pkg::SP_STEP;
      stackBus.wrData = pushData;
      isReturn = instrValid && srx_is_return(instrWord);
      if (isReturn) begin
         ip_d   = stackBus.rdData;
         sp_d   = sp_q + srx_pkg::SP_STEP;
         flags_d = flags_q;
         done_d = 1'b1;
      end else begin
         if (instrValid) begin
            ip_d = ip_q + srx_pkg::IP_STEP;
         end
         // push and flag writes yield to a return in the same cycle
         if (pushValid) begin
            sp_d = sp_q - srx_pkg::SP_STEP;
            stackBus.wrEn = 1'b1;
         end
         if (flagWrEn) begin
            flags_d = flagWrData;
         end
      end
      // read address tracks the next pointer so top word is ready
      // reading sp_d rather than sp_q hides the registered read latency
      stackBus.rdAddr = sp_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // register the state
   // reset gives the pointers known values, stack words stay unknown
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ip_q    <= srx_pkg::IP_RESET;
         sp_q    <= srx_pkg::SP_RESET;
         flags_q <= srx_pkg::FLAGS_RESET;
         done_q  <= 1'b0;
      end else begin
         ip_q    <= ip_d;
         sp_q    <= sp_d;
         flags_q <= flags_d;
         done_q  <= done_d;
      end
   end

   // outputs come straight from the flops
   assign instructionPointer = ip_q;
   assign stackPointer       = sp_q;
   assign statusFlags        = flags_q;
   assign returnDone         = done_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   // checks are off while reset is low, pointers are forced then
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   // a return decoded in this cycle
   sequence s_ret;
      instrValid && srx_is_return(instrWord);
   endsequence

   // an ordinary instruction, with or without a push
   sequence s_plain;
      instrValid && !srx_is_return(instrWord);
   endsequence

   // a push taken this cycle, a return in the same cycle blocks it
   sequence s_push;
      pushValid && !(instrValid && srx_is_return(instrWord));
   endsequence

   // popped word lands in the pointer one edge later
   property p_ip_from_stack;
      logic [15:0] top;
      (s_ret, top = stackBus.rdData) |=> (instructionPointer == top);
   endproperty
   a_ip_from_stack: assert property (p_ip_from_stack)
      else $error("return did not load pointer from stack top");

   // stack pointer steps up by exactly one
   property p_sp_pop;
      s_ret |=> (stackPointer == 4'($past(stackPointer) + 4'h1));
   endproperty
   a_sp_pop: assert property (p_sp_pop)
      else $error("return did not increment stack pointer");

   // back-to-back returns step the stack pointer up by two
   property p_sp_next_top;
      s_ret ##1 s_ret |=> (stackPointer == 4'($past(stackPointer, 2)
                                              + 4'h2));
   endproperty
   a_sp_next_top: assert property (p_sp_next_top)
      else $error("back to back returns lost a pop");

   // flags stay as they were
   property p_flags_hold;
      s_ret |=> $stable(statusFlags);
   endproperty
   a_flags_hold: assert property (p_flags_hold)
      else $error("return disturbed status flags");

   // decode strobe follows the exact opcode only
   property p_decode;
      (instrValid && (instrWord == srx_pkg::RETURN_OPCODE)) |=> returnDone;
   endproperty
   a_decode: assert property (p_decode)
      else $error("return opcode not recognised");

   // and nothing but that opcode raises the strobe
   property p_no_false_decode;
      !(instrValid && (instrWord == srx_pkg::RETURN_OPCODE)) |=> !returnDone;
   endproperty
   a_no_false_decode: assert property (p_no_false_decode)
      else $error("return strobe without return opcode");

   // non-return steps the pointer by one
   property p_seq_step;
      s_plain |=> (instructionPointer ==
                   16'($past(instructionPointer) + 16'h0001));
   endproperty
   a_seq_step: assert property (p_seq_step)
      else $error("ordinary instruction did not step pointer");

   // return completes in one cycle, no increment on top
   property p_one_cycle;
      s_ret |=> (returnDone && (instructionPointer ==
                 $past(stackBus.rdData)));
   endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("return took more than one cycle");

   // a word pushed just before a return comes straight back out,
   // which leans on the write-through path of the stack memory
   property p_push_then_ret;
      s_push ##1 s_ret |=> (instructionPointer == $past(pushData, 2));
   endproperty
   a_push_then_ret: assert property (p_push_then_ret)
      else $error("return missed the word pushed just before it");

   // a push after a return reuses the slot the return freed
   property p_sp_after_pop;
      s_ret ##1 s_push |=> (stackPointer == $past(stackPointer, 2));
   endproperty
   a_sp_after_pop: assert property (p_sp_after_pop)
      else $error("push after return used a stale stack pointer");

   // a stalled slot leaves the fetch address where it was, so only
   // a taken instruction or a return can move it
   property p_stall_hold;
      !instrValid |=> $stable(instructionPointer);
   endproperty
   a_stall_hold: assert property (p_stall_hold)
      else $error("fetch address moved during a stall");

endmodule : srx_return_exec
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the subroutine return slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [15:0] retWord = 16'h8c0d; // return encoding
   logic        clock;
   logic        resetn;
   logic        instrValid;
   logic [15:0] instrWord;
   logic        pushValid;
   logic [15:0] pushData;
   logic        flagWrEn;
   logic [7:0]  flagWrData;
   logic [15:0] instructionPointer;
   logic [3:0]  stackPointer;
   logic [7:0]  statusFlags;
   logic        returnDone;
   int          fails;         // mismatches seen
   int          compares;      // comparisons made
   logic [31:0] rngState;      // xorshift state
   logic [15:0] modelStack [16]; // bench copy of stack words
   logic [15:0] modelWritten;  // slots holding a known word
   logic [3:0]  modelSp;       // bench copy of pointer
   logic [15:0] modelIp;       // bench copy of fetch address
   logic [7:0]  modelFlags;    // bench copy of flags
   logic [27:0] expQ [$];      // notes: ip, sp, flags per return

   srx_return_exec i_dut (
      .clock(clock), .resetn(resetn), .instrValid(instrValid),
      .instrWord(instrWord), .pushValid(pushValid), .pushData(pushData),
      .flagWrEn(flagWrEn), .flagWrData(flagWrData),
      .instructionPointer(instructionPointer), .stackPointer(stackPointer),
      .statusFlags(statusFlags), .returnDone(returnDone));

   ////////////////////////////////////////////////////////////////////////
   // fixed-seed random source
   function automatic logic [31:0] nextRand();
      rngState ^= rngState << 13;
      rngState ^= rngState >> 17;
      rngState ^= rngState << 5;
      return rngState;
   endfunction : nextRand

   // single compare point, counts and reports
   task automatic check(input logic [27:0] seen, input logic [27:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check

   // verdict and end of run
   task automatic conclude();
      if (fails == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   // one core cycle of stimulus, model follows the rules
   task automatic step(input logic iv, input logic [15:0] iw,
                       input logic pv, input logic [15:0] pd,
                       input logic fe, input logic [7:0] fd);
      @(posedge clock);
      instrValid <= iv;
      instrWord  <= iw;
      pushValid  <= pv;
      pushData   <= pd;
      flagWrEn   <= fe;
      flagWrData <= fd;
      if (iv && iw == retWord) begin
         // side ports ignored, flags kept, pop top word
         expQ.push_back({modelStack[modelSp], modelSp + 4'h1, modelFlags});
         modelIp = modelStack[modelSp];
         modelSp = modelSp + 4'h1;
      end else begin
         // a taken ordinary instruction steps the fetch address
         if (iv) begin
            modelIp = modelIp + 16'h0001;
         end
         if (pv) begin
            modelSp = modelSp - 4'h1;
            modelStack[modelSp] = pd;
            modelWritten[modelSp] = 1'b1;
         end
         if (fe) begin
            modelFlags = fd;
         end
      end
   endtask : step

   ////////////////////////////////////////////////////////////////////////
   // clock, 5 ns period
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // result watcher: oldest note against each return pulse
   always @(posedge clock) begin
      if (resetn === 1'b1 && returnDone !== 1'b0) begin
         if (expQ.size() == 0) begin
            check({27'h0, returnDone}, 28'h0);
         end else begin
            check({instructionPointer, stackPointer, statusFlags},
                  expQ.pop_front());
         end
      end
   end

   // main sequence
   initial begin
      logic [31:0] rnd;
      fails = 0;
      compares = 0;
      rngState = 32'h00017b13;
      modelSp = 4'h0;
      modelIp = srx_pkg::IP_RESET;
      modelFlags = 8'h00;
      modelWritten = 16'h0000;
      resetn = 1'b0;
      instrValid = 1'b0;
      instrWord = 16'h0000;
      pushValid = 1'b0;
      pushData = 16'h0000;
      flagWrEn = 1'b0;
      flagWrData = 8'h00;
      repeat (5) @(posedge clock);
      check({instructionPointer, stackPointer, statusFlags},
            {srx_pkg::IP_RESET, srx_pkg::SP_RESET,
             srx_pkg::FLAGS_RESET});
      resetn <= 1'b1;
      // pushes, then back-to-back pops that wrap the pointer
      for (int i = 0; i < 4; i++) begin
         rnd = nextRand();
         step(1'b0, retWord, 1'b1, rnd[15:0], 1'b1, rnd[23:16]);
      end
      for (int i = 0; i < 4; i++) begin
         rnd = nextRand();
         step(1'b1, retWord, 1'b1, rnd[15:0], 1'b1, rnd[23:16]);
      end
      // single-bit neighbours and stalled return do not decode
      for (int b = 0; b < 16; b++) begin
         step(1'b1, retWord ^ (16'h0001 << b), 1'b0, 16'h0, 1'b0, 8'h0);
      end
      step(1'b0, retWord, 1'b0, 16'h0000, 1'b0, 8'h00);
      @(posedge clock);
      check({8'h00, instructionPointer, stackPointer},
            {8'h00, modelIp, modelSp});
      // random mix of pushes, flag loads and returns
      for (int i = 0; i < 200; i++) begin
         rnd = nextRand();
         if (rnd[0] && modelWritten[modelSp]) begin
            step(1'b1, retWord, rnd[1], rnd[31:16], rnd[2], rnd[15:8]);
         end else begin
            step(rnd[3], rnd[31:16] | 16'h0100, rnd[1], rnd[15:0],
                 rnd[2], rnd[15:8]);
         end
      end
      step(1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0, 8'h00);
      // bounded drain of outstanding notes
      for (int w = 0; w < 10 && expQ.size() > 0; w++) begin
         @(posedge clock);
      end
      // one more edge so the last random step has landed
      @(posedge clock);
      check({instructionPointer, stackPointer, statusFlags},
            {modelIp, modelSp, modelFlags});
      if (expQ.size() > 0) begin
         fails++;
      end
      conclude();
   end
endmodule : testbench
`default_nettype wire
